// ===== rtl/flash_register_and_array_write_protect.sv
/*
  register and array write protection of a serial flash, with the
  register set reached over axi4-lite. writes to a register offset act
  as register-write commands, gated by the enable latches and locks.
  assumes one aclk domain; the protect pin is asynchronous.
*/
// Contract
// RULE1: lock bit in config1 volatile bit 0, pin protect in status1 volatile bit 7.
// RULE2: all three lock bits zero allows every register write regardless of pin.
// RULE3: pin protect set and pin low rejects protected register writes.
// RULE4: pin protect set and pin high allows protected register writes.
// RULE5: volatile lock set blocks protected writes until power cycle.
// RULE6: lock default set makes protected registers permanently unwritable; the code clears the lock default on every aresetn.
// RULE7: pin protect reloads from nonvolatile copy on any reset.
// RULE8: volatile lock reloads from lock default on power or hardware reset.
// RULE9: lock default writable only while protection mode low bits are 111.
// RULE10: lock default set makes volatile lock unwritable.
// RULE11: quad modes force internal protect level high.
// RULE12: progress, enable latch and suspend flags are read only.
// RULE13: nonvolatile copies need write enable first; refused when protected.
// RULE14: volatile copies need an enable first; refused when protected.
// RULE15: config3 volatile is never lock protected.
// RULE16: select bit picks legacy ranges or individual locks, never both.
// RULE17: pointer region enabled by address bit 10 zero, ORed in.
// RULE18: four range bits size, top/bottom picks end, complement inverts.
// RULE19: top end complemented: 0 all, 1..9 leave top 2^(n-1) open, else none.
// RULE20: top end plain: 0 none, 1..9 protect top 2^(n-1), else all.
// RULE21: bottom complemented: 0 all, 1..9 leave bottom open, else none.
// RULE22: individual locking protects any block whose lock bit reads 0.
`timescale 1ns/100ps
module flash_register_and_array_write_protect
  import write_protect_pkg::*;
#(
  parameter int BLOCKS = 512
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // device pin and status
  input wire logic write_protect_n,
  output logic regs_locked
);
  localparam int BW = $clog2(BLOCKS);

  if (BLOCKS != 512) begin : g_bad_blocks
    $error("range tables serve 512 blocks only");
  end

  // architectural state
  logic [7:2] status_reg1_volatile;
  logic [7:0] status_reg1_nonvolatile;
  logic [7:0] config_reg1_volatile, config_reg1_nonvolatile;
  logic [7:0] config_reg2_volatile, config_reg2_nonvolatile;
  logic [7:0] config_reg3_volatile, config_reg3_nonvolatile;
  logic [7:0] training_pattern_volatile, training_pattern_nonvolatile;
  logic [2:0] protection_mode_register;
  logic write_enable_latch_flag, vol_enable_latch;
  logic reject_flag;
  logic [BW-1:0] query_block;
  logic [10:0] pointer_region;
  logic [BLOCKS-1:0] individual_block_lock;
  logic wp_meta, wp_sync;
  logic [7:2] next_st1v;
  logic [7:0] next_st1nv, next_cf1v, next_cf1nv, next_cf2v, next_cf2nv;
  logic [7:0] next_cf3v, next_cf3nv, next_tpv, next_tpnv;
  logic [2:0] next_pmr;
  logic next_wel, next_vel, next_reject;
  logic [BW-1:0] next_query;
  logic [10:0] next_pointer;
  logic [BLOCKS-1:0] next_lock;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic next_regs_locked;

  // derived protection terms
  logic wp_internal, locked, wr_fire, rd_fire, mapped_wr, mapped_rd;
  logic protected_target, nv_target, enabled, accept, lock_default;
  logic [7:0] wbyte;
  logic [BLOCKS-1:0] legacy_map, pointer_map, array_map;
  logic [BW:0] range_count;
  logic [3:0] bp_code;

  // quad modes turn the pin into a data line, so protect reads high
  assign wp_internal = config_reg2_volatile[CR2_QUAD_CMD] | config_reg1_volatile[CR1_QUAD_IO]
    | wp_sync; // RULE11
  assign lock_default = config_reg1_nonvolatile[CR1_LOCK];
  // one-time lock, run-time lock, or pin lock
  assign locked = lock_default // RULE6
    | config_reg1_volatile[CR1_LOCK] // RULE5 RULE1
    | (status_reg1_volatile[SR1_PIN_PROTECT] & ~wp_internal); // RULE2 RULE3 RULE4

  assign wr_fire = awready & awvalid & wvalid;
  assign rd_fire = arready & arvalid;
  assign wbyte = wdata[7:0];
  assign mapped_wr = (awaddr[1:0] == 2'h0) && (awaddr <= OFS_BLOCK_LOCK);
  assign mapped_rd = (araddr[1:0] == 2'h0) && (araddr <= OFS_BLOCK_LOCK);
  // config3 volatile and the array-side registers sit outside the lock set
  assign protected_target = (awaddr <= OFS_TPNV) && (awaddr != OFS_CF3V); // RULE15
  assign nv_target = awaddr[2] && (awaddr <= OFS_TPNV);
  // nonvolatile copies need 06h; volatile copies take 06h or 50h
  assign enabled = nv_target ? write_enable_latch_flag // RULE13
    : (write_enable_latch_flag | vol_enable_latch); // RULE14
  assign accept = enabled && !(protected_target && locked);

  // legacy range: count of protected blocks at the chosen end
  assign bp_code = status_reg1_volatile[5:SR1_BP_LO];
  always_comb begin
    if (bp_code == 4'h0) begin
      range_count = '0;
    end else if (bp_code >= 4'hA) begin
      range_count = (BW+1)'(BLOCKS);
    end else begin
      range_count = (BW+1)'(1) << (bp_code - 4'h1); // RULE18
    end
  end

  // per-block maps; complement inverts the plain range
  genvar gi;
  generate
    for (gi = 0; gi < BLOCKS; gi++) begin : g_block
      logic in_range;
      assign in_range = status_reg1_volatile[SR1_TOP_BOTTOM]
        ? ((BW+1)'(gi) < range_count)
        : ((BW+1)'(gi) >= (BW+1)'(BLOCKS) - range_count); // RULE18
      assign legacy_map[gi] = in_range ^ config_reg1_volatile[CR1_COMPLEMENT]; // RULE19 RULE20 RULE21
      assign pointer_map[gi] = !pointer_region[PTR_DISABLE]
        && (pointer_region[PTR_TOP] ? (BW'(gi) >= pointer_region[BW-1:0])
                                    : (BW'(gi) <= pointer_region[BW-1:0])); // RULE17
      // select bit chooses exactly one scheme, pointer region ORed on top
      assign array_map[gi] = (config_reg2_volatile[CR2_SELECT]
        ? !individual_block_lock[gi] : legacy_map[gi]) | pointer_map[gi]; // RULE16 RULE22
    end
  endgenerate

  // next state of registers and bus
  always_comb begin
    next_st1v = status_reg1_volatile;
    next_st1nv = status_reg1_nonvolatile;
    next_cf1v = config_reg1_volatile;
    next_cf1nv = config_reg1_nonvolatile;
    next_cf2v = config_reg2_volatile;
    next_cf2nv = config_reg2_nonvolatile;
    next_cf3v = config_reg3_volatile;
    next_cf3nv = config_reg3_nonvolatile;
    next_tpv = training_pattern_volatile;
    next_tpnv = training_pattern_nonvolatile;
    next_pmr = protection_mode_register;
    next_wel = write_enable_latch_flag;
    next_vel = vol_enable_latch;
    next_reject = reject_flag;
    next_query = query_block;
    next_pointer = pointer_region;
    next_lock = individual_block_lock;
    next_awready = awvalid & wvalid & ~awready & ~bvalid;
    next_wready = awvalid & wvalid & ~awready & ~bvalid;
    next_bvalid = bvalid & ~bready;
    next_bresp = bresp;
    next_arready = arvalid & ~arready & ~rvalid;
    next_rvalid = rvalid & ~rready;
    next_rresp = rresp;
    next_rdata = rdata;
    next_regs_locked = locked;
    // software clears the reject flag by writing one
    if (wr_fire && awaddr == OFS_STAT && wstrb[0] && wbyte[STAT_REJECT]) begin
      next_reject = 1'b0;
    end
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp = mapped_wr ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr_fire && mapped_wr && wstrb[0]) begin
      if (awaddr == OFS_CMD) begin
        case (wbyte)
          CMD_WRITE_ENABLE: next_wel = 1'b1;
          CMD_VOL_ENABLE: next_vel = 1'b1;
          CMD_WRITE_DISABLE: begin
            next_wel = 1'b0;
            next_vel = 1'b0;
          end
          CMD_SOFT_RESET: begin
            // soft reset reloads pin protect but keeps the run-time lock
            next_st1v[SR1_PIN_PROTECT] = status_reg1_nonvolatile[SR1_PIN_PROTECT]; // RULE7
            next_tpv = training_pattern_nonvolatile;
            next_wel = 1'b0;
            next_vel = 1'b0;
          end
          default: next_wel = write_enable_latch_flag;
        endcase
      end else if (awaddr == OFS_QUERY) begin
        next_query = wdata[BW-1:0];
      end else if (awaddr != OFS_STAT) begin
        next_wel = 1'b0;
        next_vel = 1'b0;
        if (accept) begin
          case (awaddr)
            OFS_ST1V: next_st1v = wbyte[7:2]; // RULE12
            OFS_ST1NV: next_st1nv = {wbyte[7:2], 2'b00}; // RULE12
            OFS_CF1V: begin
              // lock default freezes the volatile lock
              next_cf1v = {1'b0, wbyte[6:1],
                lock_default ? config_reg1_volatile[CR1_LOCK] : wbyte[CR1_LOCK]}; // RULE10 RULE12
            end
            OFS_CF1NV: begin
              next_cf1nv = {1'b0, wbyte[6:1], (protection_mode_register == PMR_ALL_ONES)
                ? wbyte[CR1_LOCK] : config_reg1_nonvolatile[CR1_LOCK]}; // RULE9
            end
            OFS_CF2V: next_cf2v = wbyte;
            OFS_CF2NV: next_cf2nv = wbyte;
            OFS_CF3V: next_cf3v = wbyte; // RULE15
            OFS_CF3NV: next_cf3nv = wbyte;
            OFS_TPV: next_tpv = wbyte;
            OFS_TPNV: next_tpnv = wbyte;
            OFS_PMR: next_pmr = wbyte[2:0];
            OFS_POINTER: next_pointer = wdata[10:0]; // RULE17
            OFS_BLOCK_LOCK: begin
              if (wdata[LOCK_GLOBAL]) begin
                next_lock = {BLOCKS{wdata[LOCK_VALUE]}};
              end else begin
                next_lock[wdata[BW-1:0]] = wdata[LOCK_VALUE];
              end
            end
            default: next_pmr = protection_mode_register;
          endcase
        end
      end
    end
    // a rejection in the clearing cycle wins over the clear
    if (wr_fire && mapped_wr && wstrb[0] && awaddr <= OFS_BLOCK_LOCK && awaddr != OFS_CMD
        && awaddr != OFS_STAT && awaddr != OFS_QUERY && !accept) begin
      next_reject = 1'b1; // RULE3 RULE5 RULE6
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp = mapped_rd ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        OFS_ST1V: next_rdata = {24'h0000_00, status_reg1_volatile,
          write_enable_latch_flag, 1'b0}; // RULE12
        OFS_ST1NV: next_rdata = {24'h0000_00, status_reg1_nonvolatile};
        OFS_CF1V: next_rdata = {24'h0000_00, config_reg1_volatile};
        OFS_CF1NV: next_rdata = {24'h0000_00, config_reg1_nonvolatile};
        OFS_CF2V: next_rdata = {24'h0000_00, config_reg2_volatile};
        OFS_CF2NV: next_rdata = {24'h0000_00, config_reg2_nonvolatile};
        OFS_CF3V: next_rdata = {24'h0000_00, config_reg3_volatile};
        OFS_CF3NV: next_rdata = {24'h0000_00, config_reg3_nonvolatile};
        OFS_TPV: next_rdata = {24'h0000_00, training_pattern_volatile};
        OFS_TPNV: next_rdata = {24'h0000_00, training_pattern_nonvolatile};
        OFS_PMR: next_rdata = {29'h0000_0000, protection_mode_register};
        OFS_STAT: next_rdata = {28'h0000_000, vol_enable_latch, write_enable_latch_flag,
          locked, reject_flag};
        OFS_QUERY: next_rdata = {7'h00, query_block, 15'h0000, array_map[query_block]};
        OFS_POINTER: next_rdata = {21'h00_0000, pointer_region};
        OFS_BLOCK_LOCK: next_rdata = {31'h0000_0000, individual_block_lock[query_block]};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // registers; nonvolatile copies model a blank part at power-on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg1_nonvolatile <= RST_REG8;
      config_reg1_nonvolatile <= RST_REG8;
      config_reg2_nonvolatile <= RST_REG8;
      config_reg3_nonvolatile <= RST_REG8;
      training_pattern_nonvolatile <= RST_REG8;
      status_reg1_volatile <= RST_REG8[7:2]; // RULE7
      config_reg1_volatile <= RST_REG8; // RULE8
      config_reg2_volatile <= RST_REG8;
      config_reg3_volatile <= RST_REG8;
      training_pattern_volatile <= RST_REG8;
      protection_mode_register <= PMR_ALL_ONES;
      write_enable_latch_flag <= 1'b0;
      vol_enable_latch <= 1'b0;
      reject_flag <= 1'b0;
      query_block <= '0;
      pointer_region <= RST_POINTER;
      individual_block_lock <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
      regs_locked <= 1'b0;
    end else begin
      status_reg1_nonvolatile <= next_st1nv;
      config_reg1_nonvolatile <= next_cf1nv;
      config_reg2_nonvolatile <= next_cf2nv;
      config_reg3_nonvolatile <= next_cf3nv;
      training_pattern_nonvolatile <= next_tpnv;
      status_reg1_volatile <= next_st1v;
      config_reg1_volatile <= next_cf1v;
      config_reg2_volatile <= next_cf2v;
      config_reg3_volatile <= next_cf3v;
      training_pattern_volatile <= next_tpv;
      protection_mode_register <= next_pmr;
      write_enable_latch_flag <= next_wel;
      vol_enable_latch <= next_vel;
      reject_flag <= next_reject;
      query_block <= next_query;
      pointer_region <= next_pointer;
      individual_block_lock <= next_lock;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      regs_locked <= next_regs_locked;
    end
  end

  // pin synchroniser, two stages before any logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_meta <= 1'b0;
      wp_sync <= 1'b0;
    end else begin
      wp_meta <= write_protect_n;
      wp_sync <= wp_meta;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_no_lock_open: assert property (!lock_default && !config_reg1_volatile[CR1_LOCK]
    && !status_reg1_volatile[SR1_PIN_PROTECT] |-> !locked) // RULE2
    else $error("unlocked state reports lock");
  a_pin_low_rejects: assert property (wr_fire && mapped_wr && wstrb[0] && protected_target
    && enabled && locked |=> reject_flag && !write_enable_latch_flag) // RULE3
    else $error("protected write not rejected");
  a_pin_high_open: assert property (status_reg1_volatile[SR1_PIN_PROTECT] && wp_internal
    && !lock_default && !config_reg1_volatile[CR1_LOCK] |-> !locked) // RULE4
    else $error("pin high still locks");
  a_lockdown_holds: assert property (config_reg1_volatile[CR1_LOCK] |=>
    config_reg1_volatile[CR1_LOCK]) // RULE5
    else $error("run-time lock dropped");
  a_otp_sticky: assert property (lock_default |=> lock_default) // RULE6
    else $error("lock default cleared");
  a_reset_reload: assert property ($past(!aresetn) |->
    config_reg1_volatile[CR1_LOCK] == lock_default
    && status_reg1_volatile[SR1_PIN_PROTECT] == status_reg1_nonvolatile[SR1_PIN_PROTECT]) // RULE8
    else $error("reset reload wrong");
  a_soft_reload: assert property (wr_fire && awaddr == OFS_CMD && wstrb[0]
    && wbyte == CMD_SOFT_RESET |=> status_reg1_volatile[SR1_PIN_PROTECT]
    == $past(status_reg1_nonvolatile[SR1_PIN_PROTECT])) // RULE7
    else $error("soft reset did not reload");
  a_default_gate: assert property (protection_mode_register != PMR_ALL_ONES |=>
    lock_default == $past(lock_default)) // RULE9
    else $error("lock default written while gated");
  a_otp_freezes: assert property (lock_default && wr_fire && awaddr == OFS_CF1V |=>
    config_reg1_volatile[CR1_LOCK] == $past(config_reg1_volatile[CR1_LOCK])) // RULE10
    else $error("volatile lock changed under default");
  a_quad_pin: assert property (config_reg2_volatile[CR2_QUAD_CMD]
    || config_reg1_volatile[CR1_QUAD_IO] |-> wp_internal) // RULE11
    else $error("quad mode left pin protect active");
  a_cr3_free: assert property (wr_fire && awaddr == OFS_CF3V && wstrb[0] && enabled
    |=> config_reg3_volatile == $past(wbyte)) // RULE15
    else $error("config3 volatile write lost");
  a_range_none: assert property (bp_code == 4'h0 && !config_reg1_volatile[CR1_COMPLEMENT]
    |-> legacy_map == '0) // RULE20
    else $error("code zero protects blocks");
  a_range_all_cmp: assert property (bp_code == 4'h0 && config_reg1_volatile[CR1_COMPLEMENT]
    |-> &legacy_map) // RULE19 RULE21
    else $error("complement code zero leaves blocks open");
endmodule : flash_register_and_array_write_protect

// ===== rtl/write_protect_pkg.sv
/*
  constants for the flash register and array write-protect block:
  register offsets, field positions, reset values, command codes.
  assumes a 32-bit axi4-lite slave with one register per aligned word.
*/
package write_protect_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_ST1V = 8'h00;
  localparam logic [7:0] OFS_ST1NV = 8'h04;
  localparam logic [7:0] OFS_CF1V = 8'h08;
  localparam logic [7:0] OFS_CF1NV = 8'h0C;
  localparam logic [7:0] OFS_CF2V = 8'h10;
  localparam logic [7:0] OFS_CF2NV = 8'h14;
  localparam logic [7:0] OFS_CF3V = 8'h18;
  localparam logic [7:0] OFS_CF3NV = 8'h1C;
  localparam logic [7:0] OFS_TPV = 8'h20;
  localparam logic [7:0] OFS_TPNV = 8'h24;
  localparam logic [7:0] OFS_PMR = 8'h28;
  localparam logic [7:0] OFS_CMD = 8'h2C;
  localparam logic [7:0] OFS_STAT = 8'h30;
  localparam logic [7:0] OFS_QUERY = 8'h34;
  localparam logic [7:0] OFS_POINTER = 8'h38;
  localparam logic [7:0] OFS_BLOCK_LOCK = 8'h3C;
  // field positions
  localparam int SR1_PIN_PROTECT = 7;
  localparam int SR1_TOP_BOTTOM = 6;
  localparam int SR1_BP_LO = 2;
  localparam int SR1_LATCH = 1;
  localparam int CR1_LOCK = 0;
  localparam int CR1_QUAD_IO = 1;
  localparam int CR1_COMPLEMENT = 6;
  localparam int CR2_SELECT = 2;
  localparam int CR2_QUAD_CMD = 3;
  localparam int PTR_TOP = 9;
  localparam int PTR_DISABLE = 10;
  localparam int LOCK_VALUE = 16;
  localparam int LOCK_GLOBAL = 31;
  localparam int STAT_REJECT = 0;
  // reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [10:0] RST_POINTER = 11'h400;
  localparam logic [2:0] PMR_ALL_ONES = 3'h7;
  // command codes
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_VOL_ENABLE = 8'h50;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h99;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : write_protect_pkg

// ===== sim/host_bus_model.sv
/*
  axi4-lite master standing in for the host that issues register writes.
  assumes one aclk domain; callers enter a task just after a rising edge.
*/
`timescale 1ns/100ps
module host_bus_model (
  // clock
  input wire logic aclk,
  // write side
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read side
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  output logic rready
);
  // idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end

  // one write; released channels show inverted payload so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                    output bit ok);
    ok = 1'b0;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge aclk);
      if (awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        r = bresp;
        ok = 1'b1;
        bready <= 1'b0;
      end
    end
    @(posedge aclk);
  endtask : wr

  // one read, same hold-until-taken discipline
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output bit ok);
    ok = 1'b0;
    v = '1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge aclk);
      if (arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        v = rdata;
        ok = 1'b1;
        rready <= 1'b0;
      end
    end
    @(posedge aclk);
  endtask : rd
endmodule : host_bus_model

// ===== sim/tb_flash_register_and_array_write_protect.sv
/*
  self-checking bench for the register and array write-protect block.
  assumes host_bus_model drives the bus; pin level is set per operation.
*/
`timescale 1ns/100ps
module tb_flash_register_and_array_write_protect;
  import write_protect_pkg::*;
  // pin level, read flag, enable command (0 none), address, data, expected
  typedef struct packed {
    logic wp;
    logic rd;
    logic [7:0] en;
    logic [7:0] ad;
    logic [31:0] d;
    logic [31:0] x;
  } row_type;
  localparam int NR = 49;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic write_protect_n = 1'b1;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, regs_locked;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int n_mismatch = 0;
  int checks_done = 0;
  // writes expect bresp, reads expect rdata
  row_type rows [NR] = '{
    '{1,1,8'h00,8'h00,32'h0,32'h0},
    '{1,0,8'h50,8'h00,32'h0000_0083,32'h0},
    '{1,1,8'h00,8'h00,32'h0,32'h0000_0080},
    '{0,0,8'h50,8'h10,32'h0000_0004,32'h0},
    '{0,1,8'h00,8'h10,32'h0,32'h0},
    '{0,1,8'h00,8'h30,32'h0,32'h0000_0003},
    '{0,0,8'h50,8'h18,32'h0000_005A,32'h0},
    '{0,1,8'h00,8'h18,32'h0,32'h0000_005A},
    '{1,0,8'h50,8'h20,32'h0000_0011,32'h0},
    '{1,1,8'h00,8'h20,32'h0,32'h0000_0011},
    '{1,0,8'h50,8'h08,32'h0000_0002,32'h0},
    '{0,0,8'h50,8'h20,32'h0000_0022,32'h0},
    '{0,1,8'h00,8'h20,32'h0,32'h0000_0022},
    '{1,0,8'h50,8'h08,32'h0,32'h0},
    '{1,0,8'h50,8'h04,32'h0000_0080,32'h0},
    '{1,1,8'h00,8'h04,32'h0,32'h0},
    '{1,0,8'h06,8'h04,32'h0000_0080,32'h0},
    '{1,1,8'h00,8'h04,32'h0,32'h0000_0080},
    '{1,0,8'h00,8'h20,32'h0000_0077,32'h0},
    '{1,1,8'h00,8'h20,32'h0,32'h0000_0022},
    '{1,0,8'h00,8'h40,32'h0,32'h0000_0002},
    '{1,0,8'h00,8'h02,32'h0,32'h0000_0002},
    '{1,0,8'h50,8'h00,32'h0000_0004,32'h0},
    '{1,0,8'h00,8'h34,32'h0000_01FF,32'h0},
    '{1,1,8'h00,8'h34,32'h0,32'h01FF_0001},
    '{1,0,8'h50,8'h08,32'h0000_0040,32'h0},
    '{1,1,8'h00,8'h34,32'h0,32'h01FF_0000},
    '{1,0,8'h50,8'h00,32'h0000_0044,32'h0},
    '{1,0,8'h00,8'h34,32'h0000_0001,32'h0},
    '{1,1,8'h00,8'h34,32'h0,32'h0001_0001},
    '{1,0,8'h50,8'h00,32'h0000_0024,32'h0},
    '{1,0,8'h00,8'h34,32'h0000_0100,32'h0},
    '{1,1,8'h00,8'h34,32'h0,32'h0100_0000},
    '{1,0,8'h50,8'h00,32'h0000_0028,32'h0},
    '{1,0,8'h00,8'h34,32'h0,32'h0},
    '{1,1,8'h00,8'h34,32'h0,32'h0},
    '{1,0,8'h50,8'h08,32'h0,32'h0},
    '{1,1,8'h00,8'h34,32'h0,32'h0000_0001},
    '{1,0,8'h50,8'h00,32'h0,32'h0},
    '{1,0,8'h50,8'h10,32'h0000_0004,32'h0},
    '{1,1,8'h00,8'h34,32'h0,32'h0000_0001},
    '{1,0,8'h50,8'h3C,32'h8001_0000,32'h0},
    '{1,1,8'h00,8'h34,32'h0,32'h0},
    '{1,0,8'h50,8'h00,32'h0000_0028,32'h0},
    '{1,1,8'h00,8'h34,32'h0,32'h0},
    '{1,0,8'h50,8'h38,32'h0000_0003,32'h0},
    '{1,1,8'h00,8'h34,32'h0,32'h0000_0001},
    '{1,0,8'h50,8'h08,32'h0000_0001,32'h0},
    '{1,0,8'h50,8'h08,32'h0,32'h0}
  };

  // clock
  initial begin
    forever #10 aclk = ~aclk;
  end

  host_bus_model u_host_bus_model (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready));

  flash_register_and_array_write_protect u_flash_register_and_array_write_protect (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .write_protect_n(write_protect_n), .regs_locked(regs_locked));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // pin settles through its two-flop sync before the access
  task automatic op(input row_type t);
    logic [1:0] r;
    logic [31:0] v;
    bit ok1, ok2;
    write_protect_n <= t.wp;
    repeat (4) @(posedge aclk);
    ok1 = 1'b1;
    if (t.en !== 8'h00) u_host_bus_model.wr(OFS_CMD, {24'h0, t.en}, r, ok1);
    if (t.rd) begin
      u_host_bus_model.rd(t.ad, v, ok2);
      // read response stands after the handshake until the next read
      check({30'h0, rresp}, {30'h0, RESP_OKAY});
    end else begin
      u_host_bus_model.wr(t.ad, t.d, r, ok2);
      v = {30'h0, r};
    end
    if (!(ok1 && ok2)) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: bus answer never came", $time);
      report_and_stop();
    end else begin
      check(v, t.x);
    end
  endtask : op

  // mid-run hardware reset, held low for three clocks, shorter than the twelve of the power-on reset
  task automatic hw_reset();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : hw_reset

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < NR; i++) op(rows[i]);
    op('{1,1,8'h00,8'h08,32'h0,32'h0000_0001});
    check({31'h0, regs_locked}, 32'h1);
    $display("table of %0d rows done", NR);
    hw_reset();
    op('{1,1,8'h00,8'h08,32'h0,32'h0});
    op('{1,0,8'h06,8'h04,32'h0000_0080,32'h0});
    op('{1,0,8'h50,8'h00,32'h0,32'h0});
    op('{1,0,8'h00,8'h2C,32'h0000_0099,32'h0});
    op('{1,1,8'h00,8'h00,32'h0,32'h0000_0080});
    op('{0,1,8'h00,8'h18,32'h0,32'h0});
    check({31'h0, regs_locked}, 32'h1);
    op('{1,1,8'h00,8'h18,32'h0,32'h0});
    check({31'h0, regs_locked}, 32'h0);
    $display("reset reload test done");
    hw_reset();
    op('{1,0,8'h06,8'h0C,32'h0000_0001,32'h0});
    op('{1,1,8'h00,8'h0C,32'h0,32'h0000_0001});
    check({31'h0, regs_locked}, 32'h1);
    hw_reset();
    op('{1,0,8'h50,8'h28,32'h0000_0006,32'h0});
    op('{1,0,8'h06,8'h0C,32'h0000_0001,32'h0});
    op('{1,1,8'h00,8'h0C,32'h0,32'h0});
    $display("lock default test done");
    report_and_stop();
  end
endmodule : tb_flash_register_and_array_write_protect
